/* File: design/asmp_defines.svh */
// timing counts and pin idle values for the static memory port
`ifndef ASMP_DEFINES_SVH
`define ASMP_DEFINES_SVH
`define ASMP_SETUP_CYC   4'h2
`define ASMP_ACCESS_CYC  4'h4
`define ASMP_HOLD_CYC    4'h1
`define ASMP_STROBE_IDLE 1'b1
`define ASMP_BE_IDLE     2'h3
`define ASMP_BE_BOTH     2'h0
`define ASMP_BE_UPPER    2'h1
`define ASMP_BE_LOWER    2'h2
`define ASMP_BE_HI_BIT   1
`endif

/* File: design/asmp_pkg.sv */
// types for the asynchronous static memory port
package asmp_pkg;
	typedef enum logic [1:0] {
		ASMP_IDLE   = 2'h0,
		ASMP_SETUP  = 2'h1,
		ASMP_ACCESS = 2'h3,
		ASMP_HOLD   = 2'h2
	} asmp_state_t;

	typedef struct packed {
		logic        write;
		logic [1:0]  bank;
		logic [23:0] addr;
		logic [1:0]  lanes;
	} asmp_req_t;
endpackage

/* File: design/asmp_port.sv */
// asynchronous static memory port: select, strobes, byte lanes and ready wait
`timescale 1ns/100ps
`include "asmp_defines.svh"
module asmp_port
	import asmp_pkg::*;
#(
	parameter int ADDR_W = 24,
	parameter int BANKS  = 4
) (
	input  wire logic              mclk,
	input  wire logic              srst,
	input  wire logic              req_valid,
	input  wire asmp_req_t         req,
	output logic                   req_ready,
	output logic                   done,
	input  wire logic              mem_ready_in,
	output logic [ADDR_W-1:0]      mem_addr_bus,
	output logic [BANKS-1:0]       bank_select_n,
	output logic [1:0]             byte_lane_enable_n,
	output logic                   mem_output_enable_n,
	output logic                   mem_read_enable_n,
	output logic                   mem_write_enable_n
);
	// the request struct fixes the address and bank widths
	if (ADDR_W != 24 || BANKS != 4) begin : g_param_check
		$error("asmp_port: only ADDR_W=24 and BANKS=4 are supported");
	end

	asmp_state_t state;
	asmp_state_t next_state;
	logic [3:0]  cnt;
	asmp_req_t   cur;

	function automatic logic [BANKS-1:0] bank_onehot_n(input logic [1:0] b);
		logic [BANKS-1:0] v;
		v = '1;
		v[b] = 1'b0;
		return v;
	endfunction

	// new request only when idle, so a stalled access is never replaced
	assign req_ready = (state == ASMP_IDLE);

	always_comb begin
		next_state = state;
		case (state)
			ASMP_IDLE: begin
				if (req_valid)
					next_state = ASMP_SETUP;
			end
			ASMP_SETUP: begin
				if (cnt == 4'h1)
					next_state = ASMP_ACCESS;
			end
			ASMP_ACCESS: begin
				if (cnt <= 4'h1 && mem_ready_in)
					next_state = ASMP_HOLD;
			end
			ASMP_HOLD: begin
				if (cnt == 4'h1)
					next_state = ASMP_IDLE;
			end
			default: next_state = ASMP_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst)
			state <= ASMP_IDLE;
		else
			state <= next_state;
	end

	// counter reloads on each phase entry; it saturates at one while waiting on ready
	always_ff @(posedge mclk) begin
		if (srst)
			cnt <= 4'h0;
		else if (next_state != state) begin
			case (next_state)
				ASMP_SETUP:  cnt <= `ASMP_SETUP_CYC;
				ASMP_ACCESS: cnt <= `ASMP_ACCESS_CYC;
				ASMP_HOLD:   cnt <= `ASMP_HOLD_CYC;
				default:     cnt <= 4'h0;
			endcase
		end else if (cnt > 4'h1)
			cnt <= cnt - 4'h1;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			cur <= '0;
		else if (req_valid && req_ready)
			cur <= req;
	end

	always_ff @(posedge mclk) begin
		if (srst)
			done <= 1'b0;
		else
			done <= (state == ASMP_HOLD) && (next_state == ASMP_IDLE);
	end

	always_ff @(posedge mclk) begin
		if (srst)
			mem_addr_bus <= '0;
		else if (req_valid && req_ready)
			mem_addr_bus <= req.addr;
	end

	// select spans setup, access and hold
	always_ff @(posedge mclk) begin
		if (srst)
			bank_select_n <= '1;
		else if (next_state == ASMP_IDLE)
			bank_select_n <= '1;
		else if (state == ASMP_IDLE)
			bank_select_n <= bank_onehot_n(req.bank);
	end

	// lanes stand for the whole access inverted lanes give 01 upper, 10 lower
	always_ff @(posedge mclk) begin
		if (srst)
			byte_lane_enable_n <= `ASMP_BE_IDLE;
		else if (next_state == ASMP_IDLE)
			byte_lane_enable_n <= `ASMP_BE_IDLE;
		else if (state == ASMP_IDLE)
			byte_lane_enable_n <= ~req.lanes;
	end

	// output enable from setup entry of a read
	always_ff @(posedge mclk) begin
		if (srst)
			mem_output_enable_n <= `ASMP_STROBE_IDLE;
		else if (state == ASMP_IDLE && next_state == ASMP_SETUP)
			mem_output_enable_n <= req.write;
		else if (next_state == ASMP_HOLD || next_state == ASMP_IDLE)
			mem_output_enable_n <= `ASMP_STROBE_IDLE;
	end

	// read enable at access entry write enable through access only idle high
	always_ff @(posedge mclk) begin
		if (srst) begin
			mem_read_enable_n  <= `ASMP_STROBE_IDLE;
			mem_write_enable_n <= `ASMP_STROBE_IDLE;
		end else begin
			mem_read_enable_n  <= !(next_state == ASMP_ACCESS && !cur.write);
			mem_write_enable_n <= !(next_state == ASMP_ACCESS && cur.write);
		end
	end

	chk_upper_lane: assert property (@(posedge mclk) disable iff (srst)
		(state == ASMP_IDLE && req_valid && req.write && req.lanes == 2'h2)
		|=> byte_lane_enable_n == `ASMP_BE_UPPER)
		else $error("upper byte write lanes wrong");
	chk_lower_lane: assert property (@(posedge mclk) disable iff (srst)
		(state == ASMP_IDLE && req_valid && req.write && req.lanes == 2'h1)
		|=> byte_lane_enable_n == `ASMP_BE_LOWER)
		else $error("lower byte write lanes wrong");
	chk_lane_stable: assert property (@(posedge mclk) disable iff (srst)
		(state != ASMP_IDLE && $past(state) != ASMP_IDLE) |-> $stable(byte_lane_enable_n))
		else $error("byte lanes changed mid access");
	chk_oe_setup: assert property (@(posedge mclk) disable iff (srst)
		(state == ASMP_IDLE && req_valid && !req.write) |=> !mem_output_enable_n)
		else $error("output enable late for read setup");
	chk_re_access: assert property (@(posedge mclk) disable iff (srst)
		$rose(state == ASMP_ACCESS) |-> (mem_read_enable_n == cur.write))
		else $error("read enable not at access start");
	chk_we_phase: assert property (@(posedge mclk) disable iff (srst)
		!mem_write_enable_n |-> (state == ASMP_ACCESS && cur.write))
		else $error("write enable outside write access");
	chk_ready_wait: assert property (@(posedge mclk) disable iff (srst)
		(state == ASMP_ACCESS && !mem_ready_in) |=> state == ASMP_ACCESS)
		else $error("access left without ready");
	chk_select_held: assert property (@(posedge mclk) disable iff (srst)
		(state != ASMP_IDLE && $past(state) != ASMP_IDLE) |-> !(&bank_select_n))
		else $error("bank select dropped mid access");
	chk_idle_quiet: assert property (@(posedge mclk) disable iff (srst)
		(state == ASMP_IDLE && $past(state) == ASMP_IDLE) |-> (&bank_select_n
		&& mem_output_enable_n && mem_read_enable_n && mem_write_enable_n
		&& byte_lane_enable_n == `ASMP_BE_IDLE))
		else $error("strobe active while idle");

	chk_oe_span: assert property (@(posedge mclk) disable iff (srst)
		(state != ASMP_IDLE) |-> (mem_output_enable_n == (cur.write || state == ASMP_HOLD)))
		else $error("output enable wrong during access");
	chk_re_phase: assert property (@(posedge mclk) disable iff (srst)
		!mem_read_enable_n |-> (state == ASMP_ACCESS && !cur.write))
		else $error("read enable outside read access");
	chk_we_whole: assert property (@(posedge mclk) disable iff (srst)
		(state == ASMP_ACCESS && cur.write) |-> !mem_write_enable_n)
		else $error("write enable gap in write access");
	chk_done_ready: assert property (@(posedge mclk) disable iff (srst)
		done |-> $past(mem_ready_in, 2))
		else $error("access ended without ready");
	chk_done_pulse: assert property (@(posedge mclk) disable iff (srst)
		done |=> !done)
		else $error("done longer than one cycle");

	cov_read: cover property (@(posedge mclk) disable iff (srst)
		!mem_read_enable_n ##[1:20] done);
	cov_write: cover property (@(posedge mclk) disable iff (srst)
		!mem_write_enable_n ##[1:20] done);
	cov_wait: cover property (@(posedge mclk) disable iff (srst)
		(state == ASMP_ACCESS && cnt == 4'h1 && !mem_ready_in)[*3]);
	cov_back_to_back: cover property (@(posedge mclk) disable iff (srst)
		done && req_valid && req_ready);
	cov_upper_write: cover property (@(posedge mclk) disable iff (srst)
		!mem_write_enable_n && byte_lane_enable_n == `ASMP_BE_UPPER);
endmodule

/* File: verification/asmp_mem_model.sv */
// memory-side model: ready answer with a programmable wait
`timescale 1ns/100ps
module asmp_mem_model (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic       mem_read_enable_n,
	input  wire logic       mem_write_enable_n,
	input  wire logic [3:0] wait_cyc,
	output logic            mem_ready_in
);
	logic [3:0] cnt;
	logic       acc;
	assign acc = !(mem_read_enable_n && mem_write_enable_n);
	always_ff @(posedge mclk) begin
		if (srst || !acc) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	assign mem_ready_in = acc && (cnt >= wait_cyc);
endmodule

/* File: verification/test_async_static_memory_port.sv */
// bench for the static memory port with a memory model
`timescale 1ns/100ps
module test_async_static_memory_port;
	import asmp_pkg::*;
	logic        mclk, srst, req_valid, req_ready, done, rdy, oe_n, re_n, we_n;
	logic [3:0]  wait_cyc, sel_n;
	logic [23:0] addr;
	logic [1:0]  be_n;
	asmp_req_t   req;
	int          error_cnt, checked;
	asmp_port i_dut (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req(req),
		.req_ready(req_ready), .done(done), .mem_ready_in(rdy), .mem_addr_bus(addr),
		.bank_select_n(sel_n), .byte_lane_enable_n(be_n), .mem_output_enable_n(oe_n),
		.mem_read_enable_n(re_n), .mem_write_enable_n(we_n));
	asmp_mem_model i_mem (.mclk(mclk), .srst(srst), .mem_read_enable_n(re_n),
		.mem_write_enable_n(we_n), .wait_cyc(wait_cyc), .mem_ready_in(rdy));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// one access; ext is the stretch a slow memory adds, xbe the lane pins expected
	task automatic run(input logic w, input logic [1:0] b, input logic [1:0] ln,
			input logic [1:0] xbe, input logic [3:0] wt, input logic [3:0] ext);
		logic [3:0]  n, oe, re, we, exp_sel;
		logic [23:0] exp_addr;
		n = 4'h1;
		oe = 4'h0;
		re = 4'h0;
		we = 4'h0;
		exp_sel = ~(4'h1 << b);
		exp_addr = {8'h5A, 6'h00, b, 8'hC3};
		wait_cyc = wt;
		req = '{w, b, exp_addr, ln};
		req_valid = 1'b1;
		@(negedge mclk);
		req_valid = 1'b0;
		chk(done, 1'b0);
		chk(sel_n, exp_sel);
		chk(be_n, xbe);
		chk(oe_n, w);
		chk(addr, exp_addr);
		while (done !== 1'b1 && n < 4'hF) begin
			oe += {3'h0, !oe_n};
			re += {3'h0, !re_n};
			we += {3'h0, !we_n};
			chk(sel_n, exp_sel);
			chk(be_n, xbe);
			chk(addr, exp_addr);
			chk(req_ready, 1'b0);
			@(negedge mclk);
			n++;
		end
		chk(req_ready, 1'b1);
		chk(n, 4'h8 + ext);
		chk(re, w ? 4'h0 : 4'h4 + ext);
		chk(we, w ? 4'h4 + ext : 4'h0);
		chk(oe, w ? 4'h0 : 4'h6 + ext);
		chk({sel_n, be_n, oe_n, re_n, we_n}, 9'h1FF);
	endtask
	task automatic read_both_lanes;
		run(1'b0, 2'h0, 2'h3, 2'h0, 4'h0, 4'h0);
	endtask
	task automatic write_upper_byte;
		run(1'b1, 2'h1, 2'h2, 2'h1, 4'h0, 4'h0);
	endtask
	task automatic write_lower_byte;
		run(1'b1, 2'h2, 2'h1, 2'h2, 4'h3, 4'h0);
	endtask
	task automatic read_slow_memory;
		run(1'b0, 2'h3, 2'h1, 2'h2, 4'h6, 4'h3);
	endtask
	task automatic write_slow_memory;
		run(1'b1, 2'h0, 2'h3, 2'h0, 4'h5, 4'h2);
	endtask
	task automatic read_no_lanes;
		run(1'b0, 2'h1, 2'h0, 2'h3, 4'h0, 4'h0);
	endtask
	initial begin
		error_cnt = 0;
		checked = 0;
		req_valid = 1'b0;
		req = '0;
		wait_cyc = 4'h0;
		srst = 1'b1;
		repeat (12) @(negedge mclk);
		srst = 1'b0;
		chk({sel_n, be_n, oe_n, re_n, we_n}, 9'h1FF);
		read_both_lanes();
		write_upper_byte();
		write_lower_byte();
		read_slow_memory();
		write_slow_memory();
		read_no_lanes();
		conclude();
	end
	initial begin
		#2000;
		error_cnt++;
		conclude();
	end
endmodule
